//--- shared/mms_pkg.sv
// Purpose: constants and types for the memory map decoder and data move sequencer
// Assumes: one clock per crystal clock, four clocks per machine cycle
// Notes:   register offsets are byte addresses on the plain register port
package mms_pkg;

	// Register offsets
	localparam logic [7:0] MMS_OFF_ROM_LIMIT = 8'h00;
	localparam logic [7:0] MMS_OFF_CLK_CTRL  = 8'h01;
	localparam logic [7:0] MMS_OFF_PWR_MGMT  = 8'h02;
	localparam logic [7:0] MMS_OFF_TA_KEY    = 8'h03;
	localparam logic [7:0] MMS_OFF_STATUS    = 8'h04;

	// Values after reset
	localparam logic [2:0] MMS_ROM_LIMIT_RST = 3'h4;
	localparam logic [2:0] MMS_STRETCH_RST   = 3'h1;
	localparam logic [1:0] MMS_DMAP_RST      = 2'h0;

	// On-chip ROM limit codes and top addresses
	localparam logic [2:0]  MMS_ROM_CODE_NONE = 3'h0;
	localparam logic [2:0]  MMS_ROM_CODE_1K   = 3'h1;
	localparam logic [2:0]  MMS_ROM_CODE_2K   = 3'h2;
	localparam logic [2:0]  MMS_ROM_CODE_4K   = 3'h3;
	localparam logic [2:0]  MMS_ROM_CODE_8K   = 3'h4;
	localparam logic [15:0] MMS_LIM_1K        = 16'h03FF;
	localparam logic [15:0] MMS_LIM_2K        = 16'h07FF;
	localparam logic [15:0] MMS_LIM_4K        = 16'h0FFF;
	localparam logic [15:0] MMS_LIM_8K        = 16'h1FFF;

	// Data map select codes and special addresses
	localparam logic [1:0]  MMS_DMAP_EXT    = 2'h0;
	localparam logic [1:0]  MMS_DMAP_INT    = 2'h1;
	localparam logic [1:0]  MMS_DMAP_LOCK   = 2'h3;
	localparam logic [15:0] MMS_SRAM_TOP    = 16'h03FF;
	localparam logic [15:0] MMS_LOCK_ADDR   = 16'hFFFC;
	localparam int          MMS_SRAM_DEPTH  = 1024;

	// Timed access unlock keys and open window
	localparam logic [7:0] MMS_TA_KEY1     = 8'hAA;
	localparam logic [7:0] MMS_TA_KEY2     = 8'h55;
	localparam logic [4:0] MMS_TA_OPEN_CYC = 5'h10;

	// Cycle counts, in clocks, and the stretch value where slow timing starts
	localparam logic [5:0] MMS_INT_MOVE_CYC  = 6'h08;
	localparam logic [5:0] MMS_FETCH_LAST    = 6'h03;
	localparam logic [5:0] MMS_FETCH_PROGRAM_FETCH_STROBE_N_AT = 6'h02;
	localparam logic [2:0] MMS_SLOW_STRETCH  = 3'h4;
	localparam logic [5:0] MMS_ALE_BASE      = 6'h01;
	localparam logic [5:0] MMS_ALE_SLOW      = 6'h05;
	localparam logic [5:0] MMS_AHOLD_SLOW    = 6'h04;
	localparam logic [5:0] MMS_SETUP_FAST    = 6'h01;
	localparam logic [5:0] MMS_SETUP_STD     = 6'h02;
	localparam logic [5:0] MMS_STROBE_FAST   = 6'h02;
	localparam logic [5:0] MMS_HOLD_FAST     = 6'h01;
	localparam logic [5:0] MMS_HOLD_STD      = 6'h02;
	localparam logic [5:0] MMS_HOLD_SLOW     = 6'h06;

	// Data move length in machine cycles per stretch value
	localparam logic [3:0] MMS_EXTERNAL_DATA_MOVE_MC [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'hA, 4'hB, 4'hC};

	// Sequencer states
	typedef enum logic [2:0] {
		MMS_IDLE,
		MMS_FETCH_ROM,
		MMS_FETCH_ROMD,
		MMS_FETCH_EXT,
		MMS_MOVE_INT,
		MMS_MOVE_EXT
	} mms_state_e;

endpackage

//--- rtl/mms_memory_ctrl.sv
// Purpose: program fetch decoder and data move bus cycle sequencer
// Assumes: synchronous ROM answers one clock after its read enable
// Notes:   p0 output enable is active low; p2 is valid while bus_active
`timescale 1ns/1ns

module mms_memory_ctrl (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Program fetch request
	input  wire logic        fetch_req,
	input  wire logic [15:0] fetch_addr,
	output logic             fetch_ready,
	output logic             fetch_done,
	output logic      [7:0]  fetch_data,
	// On-chip ROM
	output logic             rom_rd_en,
	output logic      [12:0] rom_addr,
	input  wire logic [7:0]  rom_data,
	// Data move request
	input  wire logic        move_req,
	input  wire logic        move_wr,
	input  wire logic [15:0] move_addr,
	input  wire logic [7:0]  move_wdata,
	output logic             move_ready,
	output logic             move_done,
	output logic      [7:0]  move_rdata,
	// Straps and fuses
	input  wire logic        external_fetch_force_n,
	input  wire logic [2:0]  security_lock_fuses,
	// External bus pins
	output logic      [7:0]  port_zero_addr_data_o,
	output logic             port_zero_addr_data_oe_n,
	input  wire logic [7:0]  port_zero_addr_data_i,
	output logic      [7:0]  port_two_addr_high,
	output logic             addr_latch_en,
	output logic             program_fetch_strobe_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             bus_active
);
	// Registers and next values
	mms_pkg::mms_state_e state_q, state_d;
	logic [2:0]  rom_limit_select_q, rom_limit_select_d;
	logic [2:0]  external_data_move_stretch_field_q, external_data_move_stretch_field_d;
	logic [1:0]  data_map_sel_q, data_map_sel_d;
	logic        ta_armed_q, ta_armed_d;
	logic [4:0]  ta_cnt_q, ta_cnt_d;
	logic [7:0]  reg_rdata_q, reg_rdata_d;
	logic [5:0]  cyc_q, cyc_d;
	logic [15:0] f_addr_q, f_addr_d, mv_addr_q, mv_addr_d;
	logic [7:0]  mv_wdata_q, mv_wdata_d, fetch_data_q, fetch_data_d, move_rdata_q, move_rdata_d;
	logic        mv_wr_q, mv_wr_d, fetch_done_q, fetch_done_d, move_done_q, move_done_d;
	logic [2:0]  mv_stretch_q, mv_stretch_d;
	logic [1:0]  mv_dmap_q, mv_dmap_d;
	logic [7:0]  sram [mms_pkg::MMS_SRAM_DEPTH];
	logic        take_fetch, take_move, fetch_internal, slow;
	logic        mv_sram, mv_lock, mv_ext, sram_we;
	logic [15:0] rom_top;
	logic [5:0]  b_ale, b_addr, b_setup, b_strobe, b_hold, b_end;
	// Handshake and request acceptance, fetch has priority
	assign fetch_ready = (state_q == mms_pkg::MMS_IDLE);
	assign move_ready  = (state_q == mms_pkg::MMS_IDLE) && !fetch_req;
	assign take_fetch  = fetch_req && fetch_ready;
	assign take_move   = move_req && move_ready;
	always_comb begin
		case (rom_limit_select_q)
			mms_pkg::MMS_ROM_CODE_1K: rom_top = mms_pkg::MMS_LIM_1K;
			mms_pkg::MMS_ROM_CODE_2K: rom_top = mms_pkg::MMS_LIM_2K;
			mms_pkg::MMS_ROM_CODE_4K: rom_top = mms_pkg::MMS_LIM_4K;
			mms_pkg::MMS_ROM_CODE_8K: rom_top = mms_pkg::MMS_LIM_8K;
			default:                  rom_top = 16'h0000;
		endcase
		fetch_internal = external_fetch_force_n &&
			(rom_limit_select_q != mms_pkg::MMS_ROM_CODE_NONE) && (fetch_addr <= rom_top);
	end
	// data move target, from latched map
	assign mv_sram = mv_dmap_q[0] && (mv_addr_q <= mms_pkg::MMS_SRAM_TOP);
	assign mv_lock = (mv_dmap_q == mms_pkg::MMS_DMAP_LOCK) && (mv_addr_q == mms_pkg::MMS_LOCK_ADDR);
	assign mv_ext  = (mv_dmap_q == mms_pkg::MMS_DMAP_EXT) ||
		((mv_dmap_q == mms_pkg::MMS_DMAP_INT) && (mv_addr_q > mms_pkg::MMS_SRAM_TOP));
	// phase boundaries of an external move
	always_comb begin
		slow     = (mv_stretch_q >= mms_pkg::MMS_SLOW_STRETCH);
		b_ale    = slow ? mms_pkg::MMS_ALE_SLOW : mms_pkg::MMS_ALE_BASE;
		b_addr   = b_ale + (slow ? mms_pkg::MMS_AHOLD_SLOW : 6'h00);
		b_setup  = b_addr + ((mv_stretch_q == 3'h0) ? mms_pkg::MMS_SETUP_FAST
			: mms_pkg::MMS_SETUP_STD);
		b_strobe = b_setup + ((mv_stretch_q == 3'h0) ? mms_pkg::MMS_STROBE_FAST
			: {1'b0, mv_stretch_q, 2'b00});
		b_hold   = b_strobe + ((mv_stretch_q == 3'h0) ? mms_pkg::MMS_HOLD_FAST
			: (slow ? mms_pkg::MMS_HOLD_SLOW : mms_pkg::MMS_HOLD_STD));
		b_end    = {mms_pkg::MMS_EXTERNAL_DATA_MOVE_MC[mv_stretch_q], 2'b00};
	end
	// Register file next values
	always_comb begin
		rom_limit_select_d   = rom_limit_select_q;
		external_data_move_stretch_field_d = external_data_move_stretch_field_q;
		data_map_sel_d       = data_map_sel_q;
		ta_armed_d           = ta_armed_q;
		ta_cnt_d             = (ta_cnt_q != 5'h00) ? ta_cnt_q - 5'h01 : 5'h00;
		reg_rdata_d          = 8'h00;
		if (reg_wr) begin
			ta_armed_d = 1'b0;
			if (reg_addr == mms_pkg::MMS_OFF_TA_KEY && reg_wdata == mms_pkg::MMS_TA_KEY1) begin
				ta_armed_d = 1'b1;
			end else if (reg_addr == mms_pkg::MMS_OFF_TA_KEY && ta_armed_q &&
				reg_wdata == mms_pkg::MMS_TA_KEY2) begin
				ta_cnt_d = mms_pkg::MMS_TA_OPEN_CYC;
			end else if (reg_addr == mms_pkg::MMS_OFF_ROM_LIMIT) begin
				ta_cnt_d = 5'h00;
				if (ta_cnt_q != 5'h00 && reg_wdata[2:0] <= mms_pkg::MMS_ROM_CODE_8K) begin
					rom_limit_select_d = reg_wdata[2:0];
				end
			end else if (reg_addr == mms_pkg::MMS_OFF_CLK_CTRL) begin
				external_data_move_stretch_field_d = reg_wdata[2:0];
			end else if (reg_addr == mms_pkg::MMS_OFF_PWR_MGMT) begin
				data_map_sel_d = reg_wdata[1:0];
			end
		end
		if (reg_rd) begin
			case (reg_addr)
				mms_pkg::MMS_OFF_ROM_LIMIT: reg_rdata_d = {5'h00, rom_limit_select_q};
				mms_pkg::MMS_OFF_CLK_CTRL:  reg_rdata_d = {5'h00, external_data_move_stretch_field_q};
				mms_pkg::MMS_OFF_PWR_MGMT:  reg_rdata_d = {6'h00, data_map_sel_q};
				mms_pkg::MMS_OFF_STATUS:    reg_rdata_d = {bus_active, (ta_cnt_q != 5'h00),
					ta_armed_q, 2'b00, security_lock_fuses};
				default:                    reg_rdata_d = 8'h00;
			endcase
		end
	end
	// Register file storage; reset values
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rom_limit_select_q   <= mms_pkg::MMS_ROM_LIMIT_RST;
			external_data_move_stretch_field_q <= mms_pkg::MMS_STRETCH_RST;
			data_map_sel_q       <= mms_pkg::MMS_DMAP_RST;
			{ta_armed_q, ta_cnt_q, reg_rdata_q} <= 14'h0000;
		end else begin
			rom_limit_select_q   <= rom_limit_select_d;
			external_data_move_stretch_field_q <= external_data_move_stretch_field_d;
			data_map_sel_q       <= data_map_sel_d;
			{ta_armed_q, ta_cnt_q, reg_rdata_q} <= {ta_armed_d, ta_cnt_d, reg_rdata_d};
		end
	end
	assign reg_rdata = reg_rdata_q;
	// Sequencer next values
	always_comb begin
		state_d      = state_q;
		cyc_d        = cyc_q + 6'h01;
		{f_addr_d, mv_addr_d, mv_wdata_d}    = {f_addr_q, mv_addr_q, mv_wdata_q};
		{mv_wr_d, mv_stretch_d, mv_dmap_d}   = {mv_wr_q, mv_stretch_q, mv_dmap_q};
		{fetch_data_d, move_rdata_d}         = {fetch_data_q, move_rdata_q};
		{fetch_done_d, move_done_d, sram_we} = 3'h0;
		case (state_q)
			mms_pkg::MMS_IDLE: begin
				cyc_d = 6'h00;
				if (take_fetch) begin
					f_addr_d = fetch_addr;
					state_d  = fetch_internal ? mms_pkg::MMS_FETCH_ROM : mms_pkg::MMS_FETCH_EXT;
				end else if (take_move) begin
					mv_addr_d    = move_addr;
					mv_wdata_d   = move_wdata;
					mv_wr_d      = move_wr;
					mv_stretch_d = external_data_move_stretch_field_q;
					mv_dmap_d    = data_map_sel_q;
					state_d      = mms_pkg::MMS_MOVE_INT;
					if ((data_map_sel_q == mms_pkg::MMS_DMAP_EXT) ||
						((data_map_sel_q == mms_pkg::MMS_DMAP_INT) &&
						(move_addr > mms_pkg::MMS_SRAM_TOP))) begin
						state_d = mms_pkg::MMS_MOVE_EXT;
					end
				end
			end
			mms_pkg::MMS_FETCH_ROM: state_d = mms_pkg::MMS_FETCH_ROMD;
			mms_pkg::MMS_FETCH_ROMD: begin
				fetch_data_d = rom_data;
				fetch_done_d = 1'b1;
				state_d      = mms_pkg::MMS_IDLE;
			end
			mms_pkg::MMS_FETCH_EXT: begin
				if (cyc_q == mms_pkg::MMS_FETCH_LAST) begin
					fetch_data_d = port_zero_addr_data_i;
					fetch_done_d = 1'b1;
					state_d      = mms_pkg::MMS_IDLE;
				end
			end
			// internal, lock byte and reserved moves
			mms_pkg::MMS_MOVE_INT: begin
				if (cyc_q == mms_pkg::MMS_INT_MOVE_CYC - 6'h01) begin
					sram_we      = mv_wr_q && mv_sram;
					move_rdata_d = mv_lock ? {5'h00, security_lock_fuses}
						: (mv_sram ? sram[mv_addr_q[9:0]] : 8'h00);
					move_done_d  = 1'b1;
					state_d      = mms_pkg::MMS_IDLE;
				end
			end
			// external move length from latched stretch
			mms_pkg::MMS_MOVE_EXT: begin
				if (!mv_wr_q && cyc_q == b_strobe - 6'h01) begin
					move_rdata_d = port_zero_addr_data_i;
				end
				if (cyc_q == b_end - 6'h01) begin
					move_done_d = 1'b1;
					state_d     = mms_pkg::MMS_IDLE;
				end
			end
			default: state_d = mms_pkg::MMS_IDLE;
		endcase
	end
	// Sequencer storage
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q      <= mms_pkg::MMS_IDLE;
			mv_stretch_q <= mms_pkg::MMS_STRETCH_RST;
			mv_dmap_q    <= mms_pkg::MMS_DMAP_RST;
			{cyc_q, f_addr_q, mv_addr_q, mv_wdata_q, mv_wr_q} <= 47'h000000000000;
			{fetch_data_q, move_rdata_q, fetch_done_q, move_done_q} <= 18'h00000;
		end else begin
			state_q      <= state_d;
			mv_stretch_q <= mv_stretch_d;
			mv_dmap_q    <= mv_dmap_d;
			{cyc_q, f_addr_q, mv_addr_q}              <= {cyc_d, f_addr_d, mv_addr_d};
			{mv_wdata_q, mv_wr_q, fetch_data_q}       <= {mv_wdata_d, mv_wr_d, fetch_data_d};
			{move_rdata_q, fetch_done_q, move_done_q} <= {move_rdata_d, fetch_done_d, move_done_d};
		end
	end
	// On-chip data SRAM, no reset
	always_ff @(posedge clock) begin
		if (sram_we) sram[mv_addr_q[9:0]] <= mv_wdata_q;
	end
	// Result outputs
	assign {fetch_done, fetch_data} = {fetch_done_q, fetch_data_q};
	assign {move_done, move_rdata}  = {move_done_q, move_rdata_q};
	assign rom_rd_en  = (state_q == mms_pkg::MMS_FETCH_ROM);
	assign rom_addr   = f_addr_q[12:0];
	// bus pin decode from state and phase count
	always_comb begin
		bus_active             = (state_q == mms_pkg::MMS_FETCH_EXT) ||
			(state_q == mms_pkg::MMS_MOVE_EXT);
		port_two_addr_high     = (state_q == mms_pkg::MMS_FETCH_EXT) ? f_addr_q[15:8]
			: mv_addr_q[15:8];
		addr_latch_en          = 1'b0;
		program_fetch_strobe_n = 1'b1;
		read_strobe_n          = 1'b1;
		write_strobe_n         = 1'b1;
		port_zero_addr_data_oe_n = 1'b1;
		port_zero_addr_data_o  = mv_addr_q[7:0];
		if (state_q == mms_pkg::MMS_FETCH_EXT) begin
			port_zero_addr_data_o    = f_addr_q[7:0];
			addr_latch_en            = (cyc_q == 6'h00);
			port_zero_addr_data_oe_n = (cyc_q >= mms_pkg::MMS_FETCH_PROGRAM_FETCH_STROBE_N_AT);
			program_fetch_strobe_n   = (cyc_q < mms_pkg::MMS_FETCH_PROGRAM_FETCH_STROBE_N_AT);
		end else if (state_q == mms_pkg::MMS_MOVE_EXT) begin
			addr_latch_en = (cyc_q < b_ale);
			if (cyc_q >= b_addr) begin
				port_zero_addr_data_o = mv_wdata_q;
			end
			port_zero_addr_data_oe_n = !((cyc_q < b_addr) || (mv_wr_q && cyc_q < b_hold));
			read_strobe_n  = !(!mv_wr_q && cyc_q >= b_setup && cyc_q < b_strobe);
			write_strobe_n = !(mv_wr_q && cyc_q >= b_setup && cyc_q < b_strobe);
		end
	end
	// Strobe low-time count, read only by the checks below
	logic [5:0] strb_run_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			strb_run_q <= 6'h00;
		end else begin
			strb_run_q <= (!read_strobe_n || !write_strobe_n) ? strb_run_q + 6'h01 : 6'h00;
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_fetch_forced_ext: assert property (take_fetch && !external_fetch_force_n |=>
		state_q == mms_pkg::MMS_FETCH_EXT) else $error("forced fetch not external");
	a_fetch_above_limit: assert property (take_fetch && fetch_addr > rom_top |=>
		state_q == mms_pkg::MMS_FETCH_EXT) else $error("fetch above limit not external");
	a_limit_code_valid: assert property (rom_limit_select_q <= mms_pkg::MMS_ROM_CODE_8K)
		else $error("rom limit holds reserved code");
	a_limit_needs_unlock: assert property (reg_wr && reg_addr == mms_pkg::MMS_OFF_ROM_LIMIT
		&& ta_cnt_q == 5'h00 |=> $stable(rom_limit_select_q)) else $error("locked limit changed");
	a_program_fetch_strobe_n_two_clocks: assert property ($fell(program_fetch_strobe_n) |->
		##1 !program_fetch_strobe_n ##1 (program_fetch_strobe_n && fetch_done))
		else $error("fetch strobe width wrong");
	a_int_move_len: assert property (take_move && state_d == mms_pkg::MMS_MOVE_INT |->
		##9 move_done) else $error("internal move not two machine cycles");
	a_no_ext_reserved: assert property (state_q == mms_pkg::MMS_MOVE_INT |->
		!addr_latch_en && read_strobe_n && write_strobe_n) else $error("bus used on internal move");
	a_strobe_width: assert property ($rose(read_strobe_n && write_strobe_n) |->
		strb_run_q == b_strobe - b_setup) else $error("strobe width wrong");
	a_ale_slow: assert property ($rose(addr_latch_en) && state_q == mms_pkg::MMS_MOVE_EXT
		&& mv_stretch_q >= mms_pkg::MMS_SLOW_STRETCH |-> addr_latch_en[*5] ##1 !addr_latch_en)
		else $error("slow latch strobe width wrong");
	a_bus_flag: assert property (addr_latch_en |-> bus_active) else $error("bus flag low");
	a_move_frozen: assert property (state_q == mms_pkg::MMS_MOVE_EXT &&
		$past(state_q) == mms_pkg::MMS_MOVE_EXT |-> $stable(mv_stretch_q) && $stable(mv_dmap_q))
		else $error("move settings changed mid access");
	c_slowest_move: cover property (move_done && mv_stretch_q == 3'h7 && mv_ext);
	c_lock_read: cover property (move_done && mv_lock && !mv_wr_q);
	c_limit_changed: cover property (reg_wr && reg_addr == mms_pkg::MMS_OFF_ROM_LIMIT
		&& ta_cnt_q != 5'h00);

endmodule

//--- tb/mms_ext_mem.sv
// Purpose: external program and data memory on the multiplexed bus
// Assumes: address is latched on every clock with the latch enable high
// Notes:   unselected bus input shows the inverse of the read value
`timescale 1ns/1ns
module mms_ext_mem (
	// Clock
	input  wire logic       clock,
	// Bus from the controller
	input  wire logic [7:0] ad_o,
	input  wire logic       ad_oe_n,
	input  wire logic [7:0] ahi,
	input  wire logic       latch_en,
	input  wire logic       fstb_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	// Bus back to the controller
	output logic      [7:0] ad_i
);
	logic [7:0] mem [256];
	logic [7:0] lo_q;
	logic [7:0] hi_q;
	logic [7:0] val;
	logic       drive;

	// Known pattern so reads can be predicted
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h3C;
		end
	end

	// low address from the shared bus, high from its own port
	always @(posedge clock) begin
		if (latch_en) begin
			lo_q <= ad_o;
			hi_q <= ahi;
		end
		if (!wr_n && !ad_oe_n) begin
			mem[lo_q] <= ad_o ^ hi_q;
		end
	end

	// Answer only while a strobe selects us and the controller has let go
	assign val   = mem[lo_q] ^ hi_q;
	assign drive = (!fstb_n || !rd_n) && ad_oe_n;
	assign ad_i  = drive ? val : ~val;
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for the memory map decoder and move sequencer
// Assumes: one clock is one crystal clock, four make a machine cycle
// Notes:   on-chip ROM is modelled here, the external bus by mms_ext_mem
`timescale 1ns/1ns
module testbench;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, fetch_data, rom_data, move_wdata, move_rdata;
	logic [7:0]  ad_o, ad_i, ahi, d;
	logic [15:0] fetch_addr, move_addr;
	logic [12:0] rom_addr;
	logic        clock, rstn, reg_wr, reg_rd, fetch_req, fetch_ready, fetch_done, rom_rd_en;
	logic        move_req, move_wr, move_ready, move_done, force_n, ad_oe_n, latch_en;
	logic        fstb_n, rd_n, wr_n, bus_active;
	logic [2:0]  fuses;
	int          error_cnt, checks, cyc, n, al, sw, fs;
	int          mc [8] = '{2, 3, 4, 5, 9, 10, 11, 12};
	logic [15:0] lim [5] = '{16'hFFFF, 16'h03FF, 16'h07FF, 16'h0FFF, 16'h1FFF};

	mms_memory_ctrl i_mms_memory_ctrl (
		.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_done(fetch_done),
		.fetch_data(fetch_data), .rom_rd_en(rom_rd_en), .rom_addr(rom_addr),
		.rom_data(rom_data), .move_req(move_req), .move_wr(move_wr), .move_addr(move_addr),
		.move_wdata(move_wdata), .move_ready(move_ready), .move_done(move_done),
		.move_rdata(move_rdata), .external_fetch_force_n(force_n),
		.security_lock_fuses(fuses), .port_zero_addr_data_o(ad_o),
		.port_zero_addr_data_oe_n(ad_oe_n), .port_zero_addr_data_i(ad_i),
		.port_two_addr_high(ahi), .addr_latch_en(latch_en), .program_fetch_strobe_n(fstb_n),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .bus_active(bus_active));

	mms_ext_mem i_mms_ext_mem (
		.clock(clock), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .ahi(ahi), .latch_en(latch_en),
		.fstb_n(fstb_n), .rd_n(rd_n), .wr_n(wr_n), .ad_i(ad_i));

	// Clock generator
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// On-chip ROM answers one clock after its read enable
	always @(posedge clock) begin
		if (rom_rd_en) rom_data <= rom_addr[7:0] ^ 8'h5A;
	end

	// Hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	function automatic logic [7:0] ext(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic unlock(input logic [7:0] code);
		wr_reg(mms_pkg::MMS_OFF_TA_KEY, 8'hAA);
		wr_reg(mms_pkg::MMS_OFF_TA_KEY, 8'h55);
		wr_reg(mms_pkg::MMS_OFF_ROM_LIMIT, code);
	endtask

	// Fetch: cycles to done in n, strobe clocks in sw
	task automatic fetch(input logic [15:0] a);
		@(posedge clock);
		fetch_req  <= 1'b1;
		fetch_addr <= a;
		@(posedge clock);
		fetch_req <= 1'b0;
		n  = 0;
		sw = 0;
		// Count from the clock that takes the request
		#1;
		while (fetch_done !== 1'b1 && n < 60) begin
			if (!fstb_n) sw++;
			@(posedge clock);
			#1 n++;
		end
		d = fetch_data;
	endtask

	// Move: length, latch clocks, strobe clocks and first strobe cycle
	task automatic move(input logic w, input logic [15:0] a, input logic [7:0] v);
		@(posedge clock);
		move_req   <= 1'b1;
		move_wr    <= w;
		move_addr  <= a;
		move_wdata <= v;
		@(posedge clock);
		move_req <= 1'b0;
		n  = 0;
		al = 0;
		sw = 0;
		fs = 0;
		// Phase count zero is seen right after the taking clock
		#1;
		while (move_done !== 1'b1 && n < 60) begin
			if (latch_en) al++;
			if ((!rd_n || !wr_n) && sw == 0) fs = n;
			if (!rd_n || !wr_n) sw++;
			@(posedge clock);
			#1 n++;
		end
		d = move_rdata;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, fetch_req, fetch_addr} = '0;
		{move_req, move_wr, move_addr, move_wdata, rom_data} = '0;
		force_n = 1'b1;
		fuses   = 3'h5;
		rstn    = 1'b0;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		rd_reg(mms_pkg::MMS_OFF_ROM_LIMIT);
		chk("limit reset", 16'h0004, {8'h00, d});
		rd_reg(mms_pkg::MMS_OFF_CLK_CTRL);
		chk("stretch reset", 16'h0001, {8'h00, d});
		rd_reg(mms_pkg::MMS_OFF_PWR_MGMT);
		chk("map reset", 16'h0000, {8'h00, d});
		rd_reg(8'h3F);
		chk("unmapped", 16'h0000, {8'h00, d});
		wr_reg(mms_pkg::MMS_OFF_ROM_LIMIT, 8'h01);
		rd_reg(mms_pkg::MMS_OFF_ROM_LIMIT);
		chk("locked limit", 16'h0004, {8'h00, d});
		$display("test reset values ended");
		// Limit change happens between fetches, never inside one
		for (int c = 0; c < 5; c++) begin
			unlock(8'(c));
			rd_reg(mms_pkg::MMS_OFF_ROM_LIMIT);
			chk("limit", 16'(c), {8'h00, d});
			if (c > 0) begin
				fetch(lim[c]);
				chk("on-chip data", {8'h00, lim[c][7:0] ^ 8'h5A}, {8'h00, d});
				chk("on-chip len", 16'h0002, 16'(n + 10 * sw));
			end
			fetch(lim[c] + 16'h0001);
			chk("off-chip data", {8'h00, ext(lim[c] + 16'h0001)}, {8'h00, d});
			chk("off-chip len", 16'h0004, 16'(n));
			chk("fetch strobe", 16'h0002, 16'(sw));
		end
		unlock(8'h05);
		rd_reg(mms_pkg::MMS_OFF_ROM_LIMIT);
		chk("reserved limit", 16'h0004, {8'h00, d});
		force_n <= 1'b0;
		fetch(16'h0010);
		chk("forced data", {8'h00, ext(16'h0010)}, {8'h00, d});
		chk("forced strobe", 16'h0002, 16'(sw));
		force_n <= 1'b1;
		$display("test fetch map ended");
		for (int s = 0; s < 8; s++) begin
			wr_reg(mms_pkg::MMS_OFF_CLK_CTRL, 8'(s));
			move(1'b0, 16'h2345, 8'h00);
			chk("move data", {8'h00, ext(16'h2345)}, {8'h00, d});
			chk("move len", 16'(4 * mc[s]), 16'(n));
			chk("strobe width", (s == 0) ? 16'h0002 : 16'(4 * s), 16'(sw));
			chk("latch width", (s >= 4) ? 16'h0005 : 16'h0001, 16'(al));
			chk("setup", 16'((s >= 4 ? 9 : 1) + (s == 0 ? 1 : 2)), 16'(fs));
		end
		fetch(16'h2000);
		chk("fetch at stretch 7", 16'h0004, 16'(n));
		fork
			move(1'b0, 16'h2345, 8'h00);
			begin
				repeat (4) @(posedge clock);
				wr_reg(mms_pkg::MMS_OFF_CLK_CTRL, 8'h00);
			end
		join
		chk("held stretch", 16'(4 * mc[7]), 16'(n));
		wr_reg(mms_pkg::MMS_OFF_CLK_CTRL, 8'h01);
		move(1'b1, 16'h4455, 8'hA5);
		move(1'b0, 16'h4455, 8'h00);
		chk("ext write back", 16'h00A5, {8'h00, d});
		$display("test stretch ended");
		wr_reg(mms_pkg::MMS_OFF_CLK_CTRL, 8'h07);
		wr_reg(mms_pkg::MMS_OFF_PWR_MGMT, 8'h01);
		move(1'b1, 16'h03FF, 8'h9A);
		move(1'b0, 16'h03FF, 8'h00);
		chk("sram data", 16'h009A, {8'h00, d});
		chk("sram len", 16'h0008, 16'(n + 10 * al));
		move(1'b0, 16'h0400, 8'h00);
		chk("above sram", {8'h00, ext(16'h0400)}, {8'h00, d});
		wr_reg(mms_pkg::MMS_OFF_PWR_MGMT, 8'h03);
		move(1'b0, 16'hFFFC, 8'h00);
		chk("lock byte", 16'h0005, {8'h00, d});
		fuses <= 3'h2;
		move(1'b0, 16'hFFFC, 8'h00);
		chk("lock byte other", 16'h0002, {8'h00, d});
		move(1'b0, 16'h0400, 8'h00);
		chk("no access", 16'h0000, 16'({d, 8'(al)}));
		wr_reg(mms_pkg::MMS_OFF_PWR_MGMT, 8'h02);
		move(1'b0, 16'h0000, 8'h00);
		chk("reserved map", 16'h0000, 16'({d, 8'(al)}));
		$display("test data map ended");
		wrap_up();
	end
endmodule
